// ---- rtl/dcpc_pkg.sv ----
`default_nettype none
package dcpc_pkg;

  // configuration word, same layout for straps and register
  typedef struct packed {
    logic [3:0] boost_sel;    // receiver boost select
    logic       data_edge;    // data_edge_rate_select
    logic       clock_edge;   // clock_edge_rate_select
    logic [3:0] spread_code;  // spread_code
    logic       low_freq;     // low_freq_range
    logic       idle_sel;     // idle_output_state_select
  } dcpc_cfg_t;

  // spread generator settings
  typedef struct packed {
    logic        en;          // modulation on
    logic [4:0]  dev_tenths;  // deviation in 0.1 percent
    logic [11:0] div;         // pixel clock divisor for rate
  } dcpc_spread_t;

  // one pixel word
  typedef struct packed {
    logic        de;          // data enable
    logic        hs;          // horizontal sync
    logic        vs;          // vertical sync
    logic [23:0] rgb;         // colour data
  } dcpc_pix_t;

  // link power and lock states
  typedef enum logic [3:0] {
    ST_OFF   = 4'h1,          // powered down
    ST_ACQ   = 4'h2,          // acquiring lock
    ST_LOCK  = 4'h4,          // locked, data valid
    ST_SLEEP = 4'h8           // stop-stream sleep
  } dcpc_state_t;

  localparam dcpc_cfg_t  CFG_RST_VALUE     = '0;      // boost off, slow edges
  localparam int         BOOST_EN_BIT      = 0;       // boost enable position
  localparam int         BOOST_STEP_LSB    = 1;       // boost step field low bit
  localparam logic [6:0] BOOST_BASE_TENTHS = 7'h0f;   // 1.5 dB at step zero
  localparam logic [6:0] BOOST_STEP_TENTHS = 7'h0f;   // 1.5 dB per step
  localparam logic [4:0] DEV_STEP_TENTHS   = 5'h05;   // 0.5 percent per step
  localparam logic [4:0] DEV_MAX_TENTHS    = 5'h14;   // 2.0 percent ceiling
  localparam int         FIFO_DEPTH        = 4;       // pixel buffer words
  localparam int         PIX_W             = $bits(dcpc_pix_t);

  // modulation divisors, normal range then low range
  localparam logic [11:0] DIV_NORM [4] = '{12'h878, 12'h514, 12'h364, 12'h28a};
  localparam logic [11:0] DIV_LOW  [4] = '{12'h26c, 12'h172, 12'h102, 12'h0c0};

  // boost gain in tenths of a dB for a select value
  function automatic logic [6:0] boost_tenths(input logic [3:0] sel);
    logic [6:0] step;
    step = {4'h0, sel[3:BOOST_STEP_LSB]};
    boost_tenths = sel[BOOST_EN_BIT] ? 7'(BOOST_BASE_TENTHS + step * BOOST_STEP_TENTHS)
                                     : 7'h00;
  endfunction

  // spread code and range to generator settings
  function automatic dcpc_spread_t spread_decode(input logic [3:0] code,
                                                 input logic       low);
    logic [3:0] idx;
    idx = code - 4'h1;
    spread_decode.en = (code != 4'h0);
    spread_decode.dev_tenths = (code == 4'h0) ? 5'h00
                             : 5'(({3'h0, idx[1:0]} + 5'h01) * DEV_STEP_TENTHS);
    if (code == 4'h0)
      spread_decode.div = 12'h000;
    else if (low)
      spread_decode.div = DIV_LOW[idx[3:2]];
    else
      spread_decode.div = DIV_NORM[idx[3:2]];
  endfunction

endpackage
`default_nettype wire

// ---- rtl/dcpc_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcpc_fifo #(
  parameter int W = 27,                  // word width
  parameter int D = 4                    // depth in words
) (
  input  wire logic         clk_i,       // clock
  input  wire logic         rst_n_i,     // async reset, active low
  input  wire logic         clr_i,       // synchronous flush
  input  wire logic [W-1:0] in_data_i,   // fill side data
  input  wire logic         in_valid_i,  // fill side valid
  output logic              in_rdy_o,    // fill side ready, registered
  output logic [W-1:0]      out_data_o,  // drain side data
  output logic              out_valid_o, // drain side valid
  input  wire logic         out_rdy_i    // drain side ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];                 // storage
  logic [AW-1:0] wr_ptr, next_wr_ptr;    // write index
  logic [AW-1:0] rd_ptr, next_rd_ptr;    // read index
  logic [AW:0]   count, next_count;      // words held
  logic          next_in_rdy;            // not full next cycle
  logic          push, pop;              // accepted transfers

  assign out_data_o  = mem[rd_ptr];
  assign out_valid_o = (count != '0);

  // pointer and level arithmetic
  always_comb
  begin
    push = in_valid_i && in_rdy_o;
    pop  = out_valid_o && out_rdy_i;
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    if (clr_i)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
    next_in_rdy = (next_count < (AW+1)'(D));
  end

  // state registers
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_rdy_o <= 1'b0;
    end
    else
    begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      count    <= next_count;
      in_rdy_o <= next_in_rdy;
    end
  end

  // storage write, no reset needed
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  fifo_bound_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    count <= (AW+1)'(D)) else $error("fifo level above depth");
endmodule
`default_nettype wire

// ---- rtl/dcpc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module dcpc_top (
  input  wire logic                  CLK_I,             // 40 MHz clock
  input  wire logic                  RSTN_I,            // async reset, active low
  input  wire logic                  POWER_DOWN_N_I,    // low powers the device down
  input  wire logic                  AUTO_DETECT_I,     // auto-detect power-down mode
  input  wire logic                  STREAM_PRESENT_I,  // embedded clock bits seen
  input  wire logic                  CDR_LOCK_DONE_I,   // recovery loop has locked
  input  wire dcpc_pkg::dcpc_cfg_t   STRAP_CFG_I,       // strap pin levels
  input  wire logic                  REG_WR_I,          // register write strobe
  input  wire dcpc_pkg::dcpc_cfg_t   REG_CFG_I,         // register write value
  input  wire dcpc_pkg::dcpc_pix_t   PIX_I,             // recovered pixel
  input  wire logic                  PIX_VALID_I,       // recovered pixel valid
  output logic                       PIX_RDY_O,         // buffer can take a pixel
  input  wire logic                  SINK_RDY_I,        // display side ready
  output dcpc_pkg::dcpc_pix_t        PIX_O,             // parallel bus data
  output logic                       PIX_VALID_O,       // parallel bus data valid
  output logic                       BUS_OE_N_O,        // data and clock drive, low drives
  output logic                       LOCK_O,            // lock indicator
  output logic                       LOCK_OE_N_O,       // lock pin drive, low drives
  output logic                       BOOST_EN_O,        // receiver boost on
  output logic [2:0]                 BOOST_STEP_O,      // boost step
  output logic [6:0]                 BOOST_TENTHS_O,    // boost in 0.1 dB
  output logic                       DATA_FAST_EDGE_O,  // data outputs fast edges
  output logic                       CLOCK_FAST_EDGE_O, // clock output fast edges
  output dcpc_pkg::dcpc_spread_t     SPREAD_O,          // spread setting, clock and data
  output logic                       POWERED_DOWN_O,    // in power-down
  output logic                       SLEEP_O,           // in stop-stream sleep
  output logic                       CFG_FROM_REG_O,    // register is the source
  output dcpc_pkg::dcpc_cfg_t        CFG_O              // configuration in use
);
  import dcpc_pkg::*;

  dcpc_state_t state, next_state;     // power and lock state
  dcpc_cfg_t   strap_cfg;             // straps caught at power-up
  dcpc_cfg_t   next_strap_cfg;        // next strap copy
  dcpc_cfg_t   reg_cfg, next_reg_cfg; // register copy
  logic        from_reg, next_from_reg;       // register written since power-up
  logic        strap_pend, next_strap_pend;   // straps still to be caught
  dcpc_cfg_t   cfg;                   // configuration in use
  dcpc_spread_t spread;               // decoded spread setting
  logic [PIX_W-1:0] fifo_data;        // buffer head
  logic        fifo_valid;            // buffer not empty
  logic        fifo_pop_rdy;          // drain side ready
  logic        fifo_clr;              // flush on power-down

  // next outputs
  dcpc_pix_t   next_pix;
  logic        next_pix_valid, next_bus_oe_n, next_lock, next_lock_oe_n;

  // configuration source: strap until register written
  assign cfg    = from_reg ? reg_cfg : strap_cfg;
  assign spread = spread_decode(cfg.spread_code, cfg.low_freq);

  // pixel buffer between recovery and output bus
  assign fifo_pop_rdy = (state == ST_LOCK) && SINK_RDY_I;
  assign fifo_clr     = (state == ST_OFF);

  dcpc_fifo #(
    .W (PIX_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .rst_n_i     (RSTN_I),
    .clr_i       (fifo_clr),
    .in_data_i   (PIX_I),
    .in_valid_i  (PIX_VALID_I && (state == ST_LOCK)),
    .in_rdy_o    (PIX_RDY_O),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_rdy_i   (fifo_pop_rdy)
  );

  // power and lock sequencing
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_OFF:
        // enable, or in auto-detect wait for the stream
        if (POWER_DOWN_N_I && (!AUTO_DETECT_I || STREAM_PRESENT_I))
          next_state = ST_ACQ;
      ST_ACQ:
        if (!POWER_DOWN_N_I)
          next_state = ST_OFF;
        else if (!STREAM_PRESENT_I && AUTO_DETECT_I)
          next_state = ST_OFF;
        else if (STREAM_PRESENT_I && CDR_LOCK_DONE_I)
          next_state = ST_LOCK;
      ST_LOCK:
        if (!POWER_DOWN_N_I)
          next_state = ST_OFF;
        else if (!STREAM_PRESENT_I)
          next_state = AUTO_DETECT_I ? ST_OFF : ST_SLEEP;
      ST_SLEEP:
        if (!POWER_DOWN_N_I || AUTO_DETECT_I)
          next_state = ST_OFF;
        else if (STREAM_PRESENT_I)
          next_state = ST_ACQ;
    endcase
  end

  // state register
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      state <= ST_OFF;
    else
      state <= next_state;
  end

  // configuration capture and register retention
  always_comb
  begin
    next_strap_cfg  = strap_cfg;
    next_reg_cfg    = reg_cfg;
    next_from_reg   = from_reg;
    next_strap_pend = strap_pend;
    if (state == ST_OFF)
    begin
      // power-down resets the control registers
      next_reg_cfg    = CFG_RST_VALUE;
      next_from_reg   = 1'b0;
      next_strap_pend = 1'b1;
    end
    else if (REG_WR_I)
    begin
      // writes land in any powered state, sleep keeps them
      next_reg_cfg  = REG_CFG_I;
      next_from_reg = 1'b1;
    end
    if (strap_pend && POWER_DOWN_N_I)
    begin
      // straps are caught as the device powers up, and every other cycle while auto-detect waits for the stream
      next_strap_cfg  = STRAP_CFG_I;
      next_strap_pend = 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      strap_cfg  <= CFG_RST_VALUE;
      reg_cfg    <= CFG_RST_VALUE;
      from_reg   <= 1'b0;
      strap_pend <= 1'b1;
    end
    else
    begin
      strap_cfg  <= next_strap_cfg;
      reg_cfg    <= next_reg_cfg;
      from_reg   <= next_from_reg;
      strap_pend <= next_strap_pend;
    end
  end

  // parallel bus and lock pin behaviour
  always_comb
  begin
    next_pix       = '0;
    next_pix_valid = 1'b0;
    next_lock      = 1'b0;
    next_lock_oe_n = 1'b0;
    next_bus_oe_n  = 1'b0;
    unique case (next_state)
      ST_OFF:
      begin
        // nothing driven while powered down
        next_lock_oe_n = 1'b1;
        next_bus_oe_n  = 1'b1;
      end
      ST_LOCK:
      begin
        // valid data only once locked
        next_lock = 1'b1;
        if (fifo_valid && fifo_pop_rdy)
        begin
          next_pix       = fifo_data;
          next_pix_valid = 1'b1;
        end
      end
      default:
        // acquiring or asleep: low or released per idle select
        next_bus_oe_n = cfg.idle_sel;
    endcase
  end

  // output registers
  always_ff @(posedge CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      PIX_O             <= '0;
      PIX_VALID_O       <= 1'b0;
      BUS_OE_N_O        <= 1'b1;
      LOCK_O            <= 1'b0;
      LOCK_OE_N_O       <= 1'b1;
      BOOST_EN_O        <= 1'b0;
      BOOST_STEP_O      <= 3'h0;
      BOOST_TENTHS_O    <= 7'h00;
      DATA_FAST_EDGE_O  <= 1'b0;
      CLOCK_FAST_EDGE_O <= 1'b0;
      SPREAD_O          <= '0;
      POWERED_DOWN_O    <= 1'b1;
      SLEEP_O           <= 1'b0;
      CFG_FROM_REG_O    <= 1'b0;
      CFG_O             <= CFG_RST_VALUE;
    end
    else
    begin
      PIX_O             <= next_pix;
      PIX_VALID_O       <= next_pix_valid;
      BUS_OE_N_O        <= next_bus_oe_n;
      LOCK_O            <= next_lock;
      LOCK_OE_N_O       <= next_lock_oe_n;
      BOOST_EN_O        <= cfg.boost_sel[BOOST_EN_BIT];
      BOOST_STEP_O      <= cfg.boost_sel[3:BOOST_STEP_LSB];
      BOOST_TENTHS_O    <= boost_tenths(cfg.boost_sel);
      DATA_FAST_EDGE_O  <= cfg.data_edge;
      CLOCK_FAST_EDGE_O <= cfg.clock_edge;
      SPREAD_O          <= spread;
      POWERED_DOWN_O    <= (next_state == ST_OFF);
      SLEEP_O           <= (next_state == ST_SLEEP);
      CFG_FROM_REG_O    <= from_reg;
      CFG_O             <= cfg;
    end
  end

  // checks
  sequence s_stream_lost;
    (state == ST_LOCK) && POWER_DOWN_N_I && !STREAM_PRESENT_I;
  endsequence
  sequence s_relock;
    (state == ST_ACQ) && POWER_DOWN_N_I && STREAM_PRESENT_I && CDR_LOCK_DONE_I;
  endsequence

  pd_enter_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    !POWER_DOWN_N_I |=> POWERED_DOWN_O && LOCK_OE_N_O && BUS_OE_N_O)
    else $error("power-down not entered");
  auto_pd_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    s_stream_lost and AUTO_DETECT_I |=> POWERED_DOWN_O && !LOCK_O)
    else $error("auto-detect power-down missed");
  sleep_enter_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    s_stream_lost and !AUTO_DETECT_I |=> SLEEP_O && !LOCK_O
      && (BUS_OE_N_O == $past(cfg.idle_sel)))
    else $error("stop-stream sleep missed");
  lock_rise_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    s_relock |=> LOCK_O && !LOCK_OE_N_O)
    else $error("lock not raised");
  valid_lock_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    PIX_VALID_O |-> LOCK_O)
    else $error("data valid without lock");
  reg_reset_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (state == ST_OFF) |=> !from_reg && (reg_cfg == CFG_RST_VALUE))
    else $error("registers kept over power-down");
  sleep_keep_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (state == ST_SLEEP) && !REG_WR_I && POWER_DOWN_N_I && !AUTO_DETECT_I
      |=> $stable(reg_cfg) && $stable(from_reg))
    else $error("registers lost in sleep");
  boost_off_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    !cfg.boost_sel[0] |=> !BOOST_EN_O && (BOOST_TENTHS_O == 7'h00))
    else $error("boost on with enable low");
  spread_dev_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    SPREAD_O.dev_tenths <= DEV_MAX_TENTHS && (SPREAD_O.en == (SPREAD_O.div != 12'h000)))
    else $error("spread deviation out of range");
  src_sel_a: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    REG_WR_I && (state != ST_OFF) |-> ##2 CFG_FROM_REG_O
      && (CFG_O == $past(REG_CFG_I, 2)))
    else $error("register source not taken");
endmodule
`default_nettype wire

// ---- tb/dcpc_ser_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// far-side stream source: embedded clock bits, recovery lock and pixel words
module dcpc_ser_model #(
  parameter int LOCK_DLY = 6                // cycles from stream start to lock
) (
  input  wire logic          clk_i,         // clock
  input  wire logic          rst_n_i,       // async reset, active low
  input  wire logic          run_i,         // stream running
  input  wire logic          feed_i,        // offer pixel words
  input  wire logic          rdy_i,         // device buffer ready
  input  wire logic          lock_i,        // device locked
  output logic               stream_o,      // embedded clock bits present
  output logic               locked_o,      // recovery loop locked
  output dcpc_pkg::dcpc_pix_t pix_o,        // pixel word
  output logic               valid_o        // pixel word valid
);
  import dcpc_pkg::*;
  logic [7:0] wait_cnt;                     // cycles since stream start
  logic       taken;                        // offered word was accepted

  // acceptance seen on the rising edge, same terms as the device
  always @(posedge clk_i)
    taken <= valid_o && rdy_i && lock_i;

  // drive after the falling edge; a word stands until it is taken
  always @(negedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stream_o <= 1'b0;
      locked_o <= 1'b0;
      wait_cnt <= 8'h00;
      valid_o  <= 1'b0;
      pix_o    <= '0;
    end
    else if (!run_i)
    begin
      stream_o <= 1'b0;
      locked_o <= 1'b0;
      wait_cnt <= 8'h00;
      valid_o  <= 1'b0;
      pix_o    <= ~pix_o;                   // released lines hold no value
    end
    else
    begin
      stream_o <= 1'b1;
      wait_cnt <= (wait_cnt < 8'(LOCK_DLY)) ? wait_cnt + 8'h01 : wait_cnt;
      locked_o <= (wait_cnt >= 8'(LOCK_DLY));
      if (taken || !valid_o)
      begin
        valid_o <= feed_i;
        pix_o   <= pix_o + 27'h0000001;     // fresh word each time
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dcpc_pkg::*;
  // modulation divisors, normal range then low range
  localparam logic [11:0] DIVS [8] = '{12'h878, 12'h514, 12'h364, 12'h28a,
                                       12'h26c, 12'h172, 12'h102, 12'h0c0};
  logic         clk = 1'b0;                 // 40 MHz clock
  logic         rstn, pwr_n, auto_det;      // reset, power pin, auto mode
  logic         run, feed, stream, cdr_done; // far side controls and status
  logic         reg_wr, pix_vin, pix_rdy;   // write strobe, pixel handshake
  logic         sink_rdy, pix_vout, lock;   // display side, lock pin
  logic         bus_oe_n, lock_oe_n, boost_en; // drive enables, boost on
  logic         data_fast, clk_fast, pd, sleep, from_reg; // status levels
  logic [2:0]   boost_step;                 // boost step
  logic [6:0]   boost_t;                    // boost in 0.1 dB
  dcpc_cfg_t    strap, reg_cfg, cfg;        // straps, write value, in use
  dcpc_pix_t    pix_in, pix_out;            // pixel words
  dcpc_spread_t spread;                     // spread setting
  int           bad_count, samples_checked, i, k; // counters, loop vars
  logic         chk_pix;                    // scoreboard active
  dcpc_pix_t    sb[$];                      // words expected on the bus
  logic [17:0]  exp_spread;                 // expected spread setting

  always #12.5 clk = ~clk;

  dcpc_top dut (.CLK_I(clk), .RSTN_I(rstn), .POWER_DOWN_N_I(pwr_n),
    .AUTO_DETECT_I(auto_det), .STREAM_PRESENT_I(stream), .CDR_LOCK_DONE_I(cdr_done),
    .STRAP_CFG_I(strap), .REG_WR_I(reg_wr), .REG_CFG_I(reg_cfg), .PIX_I(pix_in),
    .PIX_VALID_I(pix_vin), .PIX_RDY_O(pix_rdy), .SINK_RDY_I(sink_rdy), .PIX_O(pix_out),
    .PIX_VALID_O(pix_vout), .BUS_OE_N_O(bus_oe_n), .LOCK_O(lock),
    .LOCK_OE_N_O(lock_oe_n), .BOOST_EN_O(boost_en), .BOOST_STEP_O(boost_step),
    .BOOST_TENTHS_O(boost_t), .DATA_FAST_EDGE_O(data_fast),
    .CLOCK_FAST_EDGE_O(clk_fast), .SPREAD_O(spread), .POWERED_DOWN_O(pd),
    .SLEEP_O(sleep), .CFG_FROM_REG_O(from_reg), .CFG_O(cfg));

  dcpc_ser_model ser (.clk_i(clk), .rst_n_i(rstn), .run_i(run), .feed_i(feed),
    .rdy_i(pix_rdy), .lock_i(lock), .stream_o(stream), .locked_o(cdr_done),
    .pix_o(pix_in), .valid_o(pix_vin));

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one whole-word write; outputs show it one rising edge after it is taken
  task automatic reg_write(input dcpc_cfg_t v);
    reg_wr = 1'b1;
    reg_cfg = v;
    cyc(1);
    reg_wr = 1'b0;
    cyc(2);
  endtask

  // condition picked for a bounded wait
  function automatic logic probe(input int sel);
    case (sel)
      0: probe = lock;
      1: probe = pix_rdy;
      default: probe = (sb.size() == 0);
    endcase
  endfunction

  // bounded wait; running out ends the run
  task automatic await(input int sel, input logic v);
    int n;
    n = 0;
    while (probe(sel) !== v && n < 200)
    begin
      cyc(1);
      n++;
    end
    if (probe(sel) !== v)
    begin
      check(probe(sel), v);
      tally_and_finish();
    end
  endtask

  // scoreboard: words taken while locked leave the bus in order
  always @(posedge clk)
  begin
    if (chk_pix && pix_vin && pix_rdy && lock)
      sb.push_back(pix_in);
    if (chk_pix && pix_vout)
    begin
      check(sb.size() != 0, 1'b1);
      if (sb.size() != 0)
        check(pix_out, sb.pop_front());
    end
  end

  initial
  begin
    rstn = 1'b0;
    pwr_n = 1'b0;
    auto_det = 1'b0;
    run = 1'b0;
    feed = 1'b0;
    reg_wr = 1'b0;
    reg_cfg = '0;
    sink_rdy = 1'b1;
    chk_pix = 1'b0;
    strap = 12'h598;                        // boost 5, fast data, spread 6
    bad_count = 0;
    samples_checked = 0;
    cyc(5);
    rstn = 1'b1;
    check({pd, bus_oe_n, lock_oe_n}, 3'h7);
    check(boost_en, 1'b0);
    reg_write(12'hf77);                     // refused while powered down
    pwr_n = 1'b1;
    cyc(3);
    check(pd, 1'b0);
    check({from_reg, cfg}, {1'b0, strap});
    check({boost_en, boost_t, data_fast, clk_fast}, {1'b1, 7'h2d, 2'h2});
    check(spread, {1'b1, 5'h0a, 12'h514});
    check(bus_oe_n, 1'b0);
    // every boost select, spread code and range, edges from code bits
    for (i = 0; i < 32; i++)
    begin
      k = i % 16 - 1;
      exp_spread = (k < 0) ? 18'h00000 : {1'b1, 5'(5 * (k % 4 + 1)), DIVS[(i / 16) * 4 + k / 4]};
      reg_write({i[3:0], i[2], i[3], i[3:0], i[4], 1'b0});
      check({from_reg, cfg}, {1'b1, i[3:0], i[2], i[3], i[3:0], i[4], 1'b0});
      check(boost_t, i[0] ? 7'(15 + 15 * (i % 16 / 2)) : 7'h00);
      check({boost_en, boost_step}, {i[0], i[3:1]});
      check({data_fast, clk_fast}, {i[2], i[3]});
      check(spread, exp_spread);
    end
    reg_write(12'hf77);                     // idle select high
    run = 1'b1;
    feed = 1'b1;
    await(0, 1'b1);
    check({lock_oe_n, bus_oe_n}, 2'h0);
    chk_pix = 1'b1;
    cyc(20);
    sink_rdy = 1'b0;                        // display stalls, buffer fills
    await(1, 1'b0);
    cyc(4);
    sink_rdy = 1'b1;
    feed = 1'b0;
    await(2, 1'b1);                         // drained to empty
    chk_pix = 1'b0;
    run = 1'b0;
    cyc(4);
    check({lock, sleep, pd}, 3'h2);
    check(cfg, 12'hf77);
    check({bus_oe_n, pix_vout}, 2'h2);
    run = 1'b1;
    await(0, 1'b1);
    check(sleep, 1'b0);
    auto_det = 1'b1;
    run = 1'b0;
    cyc(4);
    check({pd, lock}, 2'h2);
    run = 1'b1;
    await(0, 1'b1);
    check({from_reg, cfg}, {1'b0, strap});
    pwr_n = 1'b0;
    cyc(2);
    check({pd, lock, bus_oe_n, lock_oe_n}, 4'hb);
    tally_and_finish();
  end
endmodule
`default_nettype wire
